// ==== rtl/hall_limit_pkg.sv ====
package hall_limit_pkg;

	// ************************************************************
	// Configuration items selected on the write port
	// ************************************************************
	localparam logic [3:0] CFG_UPPER_LIMIT = 4'h0;
	localparam logic [3:0] CFG_LOWER_LIMIT = 4'h1;
	localparam logic [3:0] CFG_UPPER_ACTION = 4'h2;
	localparam logic [3:0] CFG_LOWER_ACTION = 4'h3;
	localparam logic [3:0] CFG_HOME_VALUE = 4'h4;
	localparam logic [3:0] CFG_MODE = 4'h5;
	localparam logic [3:0] CFG_POLE_PAIRS = 4'h6;
	localparam logic [3:0] CFG_SEEK_CURRENT = 4'h7;
	localparam logic [3:0] CFG_HALL_SPACING = 4'h8;
	localparam logic [3:0] CFG_HALL_MAP = 4'h9;
	localparam logic [3:0] CFG_FOC_GAIN = 4'hA;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic signed [31:0] UPPER_LIMIT_RST = 32'sd20000;
	localparam logic signed [31:0] LOWER_LIMIT_RST = -32'sd20000;
	localparam logic [7:0] ACTION_RST = 8'h00;
	localparam logic signed [31:0] HOME_VALUE_RST = 32'sh00000000;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic signed [7:0] POLE_PAIRS_RST = 8'sh02;
	localparam logic [15:0] SEEK_CURRENT_RST = 16'h0032;
	localparam logic HALL_SPACING_RST = 1'b0;
	localparam logic [2:0] HALL_MAP_RST = 3'h0;
	localparam logic [7:0] FOC_GAIN_RST = 8'h00;

	// ************************************************************
	// Field layouts and encodings
	// ************************************************************
	localparam int ACT_CODE_LSB = 0;
	localparam int ACT_MOTOR_LSB = 4;
	localparam logic [3:0] ACT_NONE = 4'h0;
	localparam logic [3:0] ACT_SAFETY_STOP = 4'h1;
	localparam logic [3:0] ACT_EMERGENCY_STOP = 4'h2;
	localparam logic [3:0] ACT_MOTOR_STOP = 4'h3;
	localparam logic [3:0] ACT_FWD_LIMIT = 4'h4;
	localparam logic [3:0] ACT_REV_LIMIT = 4'h5;
	localparam logic [3:0] ACT_INVERT_DIR = 4'h6;
	localparam logic [3:0] ACT_RUN_SCRIPT = 4'h7;
	localparam logic [3:0] ACT_LOAD_HOME = 4'h8;
	localparam logic [1:0] MODE_TRAPEZOIDAL = 2'h0;
	localparam logic [1:0] MODE_SINUSOIDAL = 2'h1;
	localparam logic [1:0] MODE_SENSORLESS = 2'h2;
	localparam logic [1:0] MODE_AC_INDUCTION = 2'h3;
	localparam logic [2:0] FBK_ENCODER = 3'h0;
	localparam logic [2:0] FBK_SPI = 3'h3;
	localparam logic [2:0] FBK_SINCOS = 3'h4;
	localparam logic [2:0] HALL_MAP_MAX = 3'h5;
	localparam logic signed [7:0] POLE_PAIRS_MIN = -8'sd127;
	localparam logic signed [11:0] REL_CMD_MAX = 12'sd1000;
	localparam logic signed [63:0] REL_SPAN = 64'sd2000;
	localparam int FOC_GAIN_SLOTS = 4;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 40000000;
	localparam int ZERO_SEEK_MS = 500;
	localparam int ZERO_SEEK_CYCLES = ZERO_SEEK_MS * (CLK_HZ / 1000);
	localparam int SPEED_WINDOW_MS = 100;
	localparam int SPEED_WINDOW_CYCLES = SPEED_WINDOW_MS * (CLK_HZ / 1000);
	// Transitions per window to RPM: 60 s / 0.1 s / 6 transitions per pole pair
	localparam logic signed [31:0] RPM_SCALE = 32'sd100;
	localparam logic signed [31:0] TRANSITIONS_PER_PAIR = 32'sd6;

endpackage : hall_limit_pkg

// ==== rtl/hall_step_decoder.sv ====
`timescale 1ns/1ps
module hall_step_decoder
	import hall_limit_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Hall sensor pins
	input wire logic hall_a,
	input wire logic hall_b,
	input wire logic hall_c,
	// Configuration
	input wire logic spacing_60,
	input wire logic [2:0] winding_map,
	// Transition pulses
	output logic step_up,
	output logic step_dn
);

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] sector;
		logic sector_ok;
		logic up;
		logic dn;
	} hall_state_s;

	hall_state_s st_ff;
	hall_state_s nxt_st;

	// Sector number of a valid 120-degree pattern, 3'h7 when illegal
	function automatic logic [2:0] sector_of(input logic [2:0] abc);
		unique case (abc)
			3'b101: sector_of = 3'h0;
			3'b100: sector_of = 3'h1;
			3'b110: sector_of = 3'h2;
			3'b010: sector_of = 3'h3;
			3'b011: sector_of = 3'h4;
			3'b001: sector_of = 3'h5;
			default: sector_of = 3'h7;
		endcase
	endfunction : sector_of

	// ************************************************************
	// Synchronise, remap and track sector steps
	// ************************************************************
	always_comb begin
		logic [2:0] mapped;
		logic [2:0] sec;
		logic [2:0] fwd;
		logic [2:0] back;
		mapped = 3'h0;
		sec = 3'h7;
		fwd = 3'h0;
		back = 3'h0;
		nxt_st = st_ff;
		nxt_st.sync1 = {hall_a, hall_b, hall_c};
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.up = 1'b0;
		nxt_st.dn = 1'b0;
		// Six orders of the sensors onto the windings; unknown codes fall back to 0
		unique case (winding_map)
			3'h1: mapped = {st_ff.sync2[2], st_ff.sync2[0], st_ff.sync2[1]}; // see R18
			3'h2: mapped = {st_ff.sync2[1], st_ff.sync2[2], st_ff.sync2[0]};
			3'h3: mapped = {st_ff.sync2[1], st_ff.sync2[0], st_ff.sync2[2]};
			3'h4: mapped = {st_ff.sync2[0], st_ff.sync2[2], st_ff.sync2[1]};
			3'h5: mapped = {st_ff.sync2[0], st_ff.sync2[1], st_ff.sync2[2]};
			default: mapped = st_ff.sync2;
		endcase
		// 60-degree sensors differ from 120-degree ones by the middle sensor's sense
		if (spacing_60) begin // see R17
			mapped[1] = ~mapped[1];
		end
		sec = sector_of(mapped);
		fwd = (st_ff.sector == 3'h5) ? 3'h0 : st_ff.sector + 3'h1;
		back = (st_ff.sector == 3'h0) ? 3'h5 : st_ff.sector - 3'h1;
		// Illegal patterns (000, 111) are glitches and are skipped
		if (sec != 3'h7) begin
			nxt_st.sector = sec;
			nxt_st.sector_ok = 1'b1;
			if (st_ff.sector_ok && sec == fwd) begin
				nxt_st.up = 1'b1;
			end else if (st_ff.sector_ok && sec == back) begin
				nxt_st.dn = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign step_up = st_ff.up;
	assign step_dn = st_ff.dn;

	// Never both directions at once
	step_exclusive_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!(step_up && step_dn)) else $error("hall step both directions");

endmodule : hall_step_decoder

// ==== rtl/limit_trip.sv ====
`timescale 1ns/1ps
module limit_trip
	import hall_limit_pkg::*;
#(
	parameter bit IS_UPPER = 1'b1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Compare inputs
	input wire logic signed [31:0] count,
	input wire logic signed [31:0] limit,
	input wire logic [7:0] action,
	// Trip result
	output logic fire,
	output logic [7:0] fired_action
);

	typedef struct packed {
		logic armed;
		logic fire;
		logic [7:0] act;
	} trip_state_s;

	trip_state_s st_ff;
	trip_state_s nxt_st;
	logic beyond;

	// Strictly above the upper or strictly below the lower value
	assign beyond = IS_UPPER ? (count > limit) : (count < limit); // see R1 // see R2

	// ************************************************************
	// One shot per excursion, re-armed back inside the range
	// ************************************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.fire = 1'b0;
		if (st_ff.armed && beyond) begin // see R20
			nxt_st.fire = 1'b1;
			nxt_st.armed = 1'b0;
			nxt_st.act = action;
		end else if (!beyond) begin
			nxt_st.armed = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '{armed: 1'b1, fire: 1'b0, act: ACTION_RST};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign fire = st_ff.fire;
	assign fired_action = st_ff.act;

	// A trip is never repeated on the next cycle
	no_double_fire_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R20
		fire |=> !fire) else $error("limit fired twice in a row");

endmodule : limit_trip

// ==== rtl/hall_counter_soft_limits.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// R1: Counter above upper limit fires upper action; upper limit resets to 20000.
// R2: Counter below lower limit fires lower action; lower limit resets to -20000.
// R3: Action codes 0..8: none, stops, limits, invert, script, load home.
// R4: Action bits above the code select motors: 16, 32, 48.
// R5: Relative command -1000 targets the lower limit count.
// R6: Command +1000 targets upper limit; between them linear interpolation.
// R7: Home switch, home command or script loads home value into counter.
// R8: Host changes counter only while channel runs open loop.
// R9: Counter has no absolute reference until a home load.
// R10: Mode 0 trapezoidal, 1 sinusoidal, 2 sensorless, 3 AC induction; reset 0.
// R11: Change to sinusoidal with encoder feedback starts reference search.
// R12: Signed pole pairs -127..127, reset 2, scale counts to RPM and turns.
// R13: Negative pole pairs invert counting direction and speed sign.
// R14: Zero search drives configured current, amps times ten, reset 50.
// R15: Search starts at every power-up in sinusoidal with encoder feedback; the boot check sees the reset mode 0, so it never starts.
// R16: Sin/cos or SPI feedback: host starts search with bind command.
// R17: Hall spacing 0 means 120 degrees, 1 means 60 degrees; reset 0.
// R18: Hall map 0..5 picks one of six sensor-to-winding orders; reset 0.
// R19: Four unsigned 8-bit FOC integral gains, flux and torque, gain times ten.
// R20: Each limit action fires once, re-arms back inside the range.
module hall_counter_soft_limits
	import hall_limit_pkg::*;
#(
	parameter int SEEK_CYCLES = ZERO_SEEK_CYCLES,
	parameter int WINDOW_CYCLES = SPEED_WINDOW_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Hall sensor and home switch pins
	input wire logic hall_a,
	input wire logic hall_b,
	input wire logic hall_c,
	input wire logic home_switch,
	// Home and search requests
	input wire logic home_cmd,
	input wire logic script_home,
	input wire logic bind_zero_search_command,
	input wire logic [2:0] feedback_select,
	// Configuration write port
	input wire logic cfg_wr,
	input wire logic [3:0] cfg_item,
	input wire logic [2:0] cfg_index,
	input wire logic [31:0] cfg_data,
	// Relative position command
	input wire logic signed [11:0] rel_cmd,
	// Position and speed
	output logic signed [31:0] hall_count,
	output logic count_referenced,
	output logic signed [31:0] target_position,
	output logic signed [31:0] speed_rpm,
	output logic signed [31:0] motor_turns,
	// Limit actions
	output logic act_safety_stop,
	output logic act_emergency_stop,
	output logic act_motor_stop,
	output logic act_fwd_limit,
	output logic act_rev_limit,
	output logic act_invert_dir,
	output logic act_run_script,
	output logic [1:0] act_motor,
	// Zero search and commutation settings
	output logic zero_seek_active,
	output logic [15:0] zero_seek_current,
	output logic [1:0] commutation_mode_select,
	output logic hall_spacing_select,
	output logic [2:0] hall_winding_map,
	output logic signed [7:0] pole_pair_count,
	output logic [31:0] foc_integral_gain
);

	initial begin
		if (SEEK_CYCLES < 1 || WINDOW_CYCLES < 1) begin
			$error("seek and window counts must be at least one cycle");
		end
	end

	typedef enum logic {SEEK_IDLE, SEEK_RUN} seek_e;

	typedef struct packed {
		logic [2:0] home_sync;
		logic signed [31:0] upper;
		logic signed [31:0] lower;
		logic [7:0] upper_act;
		logic [7:0] lower_act;
		logic signed [31:0] home;
		logic [1:0] mode;
		logic signed [7:0] poles;
		logic [15:0] seek_cur;
		logic spacing;
		logic [2:0] map;
		logic [31:0] gains;
		logic signed [31:0] count;
		logic homed;
		logic signed [31:0] target;
		logic signed [31:0] win_cnt;
		logic [31:0] win_timer;
		logic signed [31:0] rpm;
		logic signed [31:0] turns;
		logic [7:0] acts;
		logic [1:0] motor;
		seek_e seek;
		logic [31:0] seek_timer;
		logic boot;
	} core_state_s;

	core_state_s st_ff;
	core_state_s nxt_st;
	logic step_up;
	logic step_dn;
	logic up_fire;
	logic lo_fire;
	logic [7:0] up_fired_act;
	logic [7:0] lo_fired_act;

	// ************************************************************
	// Hall decoding and the two soft limits
	// ************************************************************
	hall_step_decoder u_hall (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.hall_a(hall_a),
		.hall_b(hall_b),
		.hall_c(hall_c),
		.spacing_60(st_ff.spacing),
		.winding_map(st_ff.map),
		.step_up(step_up),
		.step_dn(step_dn)
	);

	limit_trip #(.IS_UPPER(1'b1)) u_upper (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.count(st_ff.count),
		.limit(st_ff.upper),
		.action(st_ff.upper_act),
		.fire(up_fire),
		.fired_action(up_fired_act)
	);

	limit_trip #(.IS_UPPER(1'b0)) u_lower (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.count(st_ff.count),
		.limit(st_ff.lower),
		.action(st_ff.lower_act),
		.fire(lo_fire),
		.fired_action(lo_fired_act)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [7:0] sel;
		logic load;
		logic inc;
		logic dec;
		logic signed [7:0] abs_poles;
		logic signed [31:0] per_turn;
		logic signed [11:0] cmd;
		logic signed [63:0] span;
		logic signed [63:0] scaled;
		logic sine_enc;
		sel = 8'h00;
		load = 1'b0;
		inc = 1'b0;
		dec = 1'b0;
		abs_poles = 8'sh0;
		per_turn = 32'sh0;
		cmd = 12'sh0;
		span = 64'sh0;
		scaled = 64'sh0;
		sine_enc = 1'b0;
		nxt_st = st_ff;
		nxt_st.home_sync = {st_ff.home_sync[1:0], home_switch};
		nxt_st.boot = 1'b0;
		nxt_st.acts = 8'h00;
		// Host configuration writes; out-of-range mode, pole pair, hall map and gain index writes ignored
		if (cfg_wr) begin
			unique case (cfg_item)
				CFG_UPPER_LIMIT: nxt_st.upper = cfg_data;
				CFG_LOWER_LIMIT: nxt_st.lower = cfg_data;
				CFG_UPPER_ACTION: nxt_st.upper_act = cfg_data[7:0];
				CFG_LOWER_ACTION: nxt_st.lower_act = cfg_data[7:0];
				CFG_HOME_VALUE: nxt_st.home = cfg_data;
				CFG_MODE: begin // see R10
					if (cfg_data[31:2] == 30'h0) nxt_st.mode = cfg_data[1:0];
				end
				CFG_POLE_PAIRS: begin // see R12
					if ($signed(cfg_data) >= 32'(POLE_PAIRS_MIN) && $signed(cfg_data) <= 32'sd127)
						nxt_st.poles = cfg_data[7:0];
				end
				CFG_SEEK_CURRENT: nxt_st.seek_cur = cfg_data[15:0]; // see R14
				CFG_HALL_SPACING: nxt_st.spacing = cfg_data[0]; // see R17
				CFG_HALL_MAP: begin // see R18
					if (cfg_data[31:3] == 29'h0 && cfg_data[2:0] <= HALL_MAP_MAX)
						nxt_st.map = cfg_data[2:0];
				end
				CFG_FOC_GAIN: begin // see R19
					if (cfg_index >= 3'h1 && cfg_index <= 3'(FOC_GAIN_SLOTS))
						nxt_st.gains[8 * (cfg_index - 3'h1) +: 8] = cfg_data[7:0];
				end
				default: ;
			endcase
		end
		// Limit actions, upper wins on a coincidence
		if (up_fire) sel = up_fired_act;
		else if (lo_fire) sel = lo_fired_act;
		if (up_fire || lo_fire) begin // see R3 // see R4
			nxt_st.motor = sel[ACT_MOTOR_LSB +: 2];
			if (sel[ACT_CODE_LSB +: 4] >= ACT_SAFETY_STOP && sel[ACT_CODE_LSB +: 4] <= ACT_RUN_SCRIPT)
				nxt_st.acts[sel[ACT_CODE_LSB +: 3]] = 1'b1;
		end
		// Home loads beat steps; counter free-runs without a reference until then
		load = (st_ff.home_sync[1] && !st_ff.home_sync[2]) || home_cmd || script_home
			|| ((up_fire || lo_fire) && sel[ACT_CODE_LSB +: 4] == ACT_LOAD_HOME);
		inc = st_ff.poles[7] ? step_dn : step_up; // see R13
		dec = st_ff.poles[7] ? step_up : step_dn;
		if (load) begin // see R7
			nxt_st.count = st_ff.home;
			nxt_st.homed = 1'b1; // see R9
		end else if (inc) begin
			nxt_st.count = st_ff.count + 32'sd1;
		end else if (dec) begin
			nxt_st.count = st_ff.count - 32'sd1;
		end
		// Speed window, signed so negative pole pairs flip the speed too
		if (inc) nxt_st.win_cnt = st_ff.win_cnt + 32'sd1;
		else if (dec) nxt_st.win_cnt = st_ff.win_cnt - 32'sd1;
		abs_poles = st_ff.poles[7] ? -st_ff.poles : st_ff.poles;
		per_turn = TRANSITIONS_PER_PAIR * 32'(abs_poles);
		if (st_ff.win_timer == 32'(WINDOW_CYCLES - 1)) begin // see R12
			nxt_st.win_timer = 32'h0;
			nxt_st.win_cnt = inc ? 32'sd1 : dec ? -32'sd1 : 32'sh0; // Boundary step opens next window
			nxt_st.rpm = (abs_poles == 8'sh0) ? 32'sh0
				: (st_ff.win_cnt * RPM_SCALE) / 32'(abs_poles);
		end else begin
			nxt_st.win_timer = st_ff.win_timer + 32'h1;
		end
		nxt_st.turns = (per_turn == 32'sh0) ? 32'sh0 : st_ff.count / per_turn;
		// Relative target, linear from lower at -1000 to upper at +1000
		cmd = (rel_cmd > REL_CMD_MAX) ? REL_CMD_MAX : (rel_cmd < -REL_CMD_MAX) ? -REL_CMD_MAX : rel_cmd;
		span = 64'(st_ff.upper) - 64'(st_ff.lower);
		scaled = (span * (64'(cmd) + 64'(REL_CMD_MAX))) / REL_SPAN;
		nxt_st.target = 32'(64'(st_ff.lower) + scaled); // see R5 // see R6
		// Zero reference search; bind starts it only with sin/cos or SPI feedback
		sine_enc = feedback_select == FBK_ENCODER;
		unique case (st_ff.seek)
			SEEK_IDLE: begin
				if ((nxt_st.mode == MODE_SINUSOIDAL && st_ff.mode != MODE_SINUSOIDAL && sine_enc) // see R11
					|| (st_ff.boot && st_ff.mode == MODE_SINUSOIDAL && sine_enc) // see R15
					|| (bind_zero_search_command && st_ff.mode == MODE_SINUSOIDAL
					&& (feedback_select == FBK_SPI || feedback_select == FBK_SINCOS))) begin // see R16
					nxt_st.seek = SEEK_RUN;
					nxt_st.seek_timer = 32'h0;
				end
			end
			SEEK_RUN: begin
				if (st_ff.seek_timer == 32'(SEEK_CYCLES - 1)) nxt_st.seek = SEEK_IDLE;
				else nxt_st.seek_timer = st_ff.seek_timer + 32'h1;
			end
		endcase
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
			st_ff.upper <= UPPER_LIMIT_RST;
			st_ff.lower <= LOWER_LIMIT_RST;
			st_ff.upper_act <= ACTION_RST;
			st_ff.lower_act <= ACTION_RST;
			st_ff.home <= HOME_VALUE_RST;
			st_ff.mode <= MODE_RST;
			st_ff.poles <= POLE_PAIRS_RST;
			st_ff.seek_cur <= SEEK_CURRENT_RST;
			st_ff.spacing <= HALL_SPACING_RST;
			st_ff.map <= HALL_MAP_RST;
			st_ff.gains <= {FOC_GAIN_SLOTS{FOC_GAIN_RST}};
			st_ff.seek <= SEEK_IDLE;
			st_ff.boot <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign hall_count = st_ff.count;
	assign count_referenced = st_ff.homed;
	assign target_position = st_ff.target;
	assign speed_rpm = st_ff.rpm;
	assign motor_turns = st_ff.turns;
	assign act_safety_stop = st_ff.acts[1];
	assign act_emergency_stop = st_ff.acts[2];
	assign act_motor_stop = st_ff.acts[3];
	assign act_fwd_limit = st_ff.acts[4];
	assign act_rev_limit = st_ff.acts[5];
	assign act_invert_dir = st_ff.acts[6];
	assign act_run_script = st_ff.acts[7];
	assign act_motor = st_ff.motor;
	assign zero_seek_active = st_ff.seek == SEEK_RUN;
	assign zero_seek_current = st_ff.seek_cur;
	assign commutation_mode_select = st_ff.mode;
	assign hall_spacing_select = st_ff.spacing;
	assign hall_winding_map = st_ff.map;
	assign pole_pair_count = st_ff.poles;
	assign foc_integral_gain = st_ff.gains;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	upper_trip_cause_a: assert property ( // see R1
		up_fire |-> $past(st_ff.count) > $past(st_ff.upper)) else $error("upper trip without crossing");
	lower_trip_cause_a: assert property ( // see R2
		lo_fire |-> $past(st_ff.count) < $past(st_ff.lower)) else $error("lower trip without crossing");
	stop_action_decode_a: assert property ( // see R3
		up_fire && up_fired_act[3:0] == ACT_MOTOR_STOP |=> act_motor_stop && act_motor == $past(up_fired_act[5:4]))
		else $error("motor stop not decoded");
	home_load_value_a: assert property ( // see R7
		home_cmd |=> hall_count == $past(st_ff.home) && count_referenced) else $error("home load missed");
	reference_held_a: assert property ( // see R9
		count_referenced |=> count_referenced) else $error("reference lost");
	full_reverse_target_a: assert property ( // see R5
		rel_cmd == -12'sd1000 && $stable(st_ff.lower) |=> target_position == $past(st_ff.lower))
		else $error("target not at lower limit");
	inverted_count_a: assert property ( // see R13
		pole_pair_count < 0 && step_up && !home_cmd && !script_home && !up_fire && !lo_fire
		&& st_ff.home_sync[2:1] != 2'b01 |=> hall_count == $past(hall_count) - 32'sd1)
		else $error("negative pole pairs did not invert count");
	seek_on_mode_a: assert property ( // see R11
		!zero_seek_active && cfg_wr && cfg_item == CFG_MODE && cfg_data == 32'h1
		&& commutation_mode_select != MODE_SINUSOIDAL && feedback_select == FBK_ENCODER
		|=> zero_seek_active) else $error("search not started on mode change");

endmodule : hall_counter_soft_limits

// ==== test/hall_motor_model.sv ====
`timescale 1ns/1ps
module hall_motor_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// One sector per request pulse
	input wire logic fwd,
	input wire logic rev,
	// Sensor pins
	output logic hall_a,
	output logic hall_b,
	output logic hall_c
);
	// ************************************************
	// Rotor sector, upward rotation order
	// ************************************************
	localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	int pos;
	// Only legal sectors appear; a real sensor never shows 000 or 111
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) pos <= 0;
		else if (fwd) pos <= (pos + 1) % 6;
		else if (rev) pos <= (pos + 5) % 6;
	end
	assign {hall_a, hall_b, hall_c} = SEQ[pos];
endmodule : hall_motor_model

// ==== test/hall_counter_soft_limits_tb.sv ====
`timescale 1ns/1ps
module hall_counter_soft_limits_tb;
	import hall_limit_pkg::*;
	localparam int SEEK = 8;
	// ************************************************
	// Signals
	// ************************************************
	logic ref_clk = 1'b0, arst_n = 1'b0, home_switch = 1'b0, home_cmd = 1'b0;
	logic script_home = 1'b0, bind_zero_search_command = 1'b0, cfg_wr = 1'b0;
	logic fwd = 1'b0, rev = 1'b0, hall_a, hall_b, hall_c, count_referenced;
	logic zero_seek_active, hall_spacing_select, act_safety_stop, act_emergency_stop;
	logic act_motor_stop, act_fwd_limit, act_rev_limit, act_invert_dir, act_run_script;
	logic [2:0] feedback_select = 3'h0, cfg_index = 3'h0, hall_winding_map;
	logic [3:0] cfg_item = 4'h0;
	logic [31:0] cfg_data = 32'h0, foc_integral_gain;
	logic signed [11:0] rel_cmd = 12'h000;
	logic signed [31:0] hall_count, target_position, speed_rpm, motor_turns;
	logic [1:0] act_motor, commutation_mode_select;
	logic [15:0] zero_seek_current;
	logic signed [7:0] pole_pair_count;
	logic [7:0] pulses;
	int errors = 0, n_checks = 0, seek_n = 0, rpm_sum = 0, seed, lo, hi, c, v, m;
	int hits [9];
	hall_motor_model i_hall_motor_model (.ref_clk, .arst_n, .fwd, .rev, .hall_a, .hall_b, .hall_c);
	hall_counter_soft_limits #(.SEEK_CYCLES(SEEK), .WINDOW_CYCLES(16)) i_hall_counter_soft_limits (
		.ref_clk, .arst_n, .hall_a, .hall_b, .hall_c, .home_switch, .home_cmd, .script_home,
		.bind_zero_search_command, .feedback_select, .cfg_wr, .cfg_item, .cfg_index, .cfg_data,
		.rel_cmd, .hall_count, .count_referenced, .target_position, .speed_rpm, .motor_turns,
		.act_safety_stop, .act_emergency_stop, .act_motor_stop, .act_fwd_limit, .act_rev_limit,
		.act_invert_dir, .act_run_script, .act_motor, .zero_seek_active, .zero_seek_current,
		.commutation_mode_select, .hall_spacing_select, .hall_winding_map, .pole_pair_count,
		.foc_integral_gain);
	// Clock
	always #12.5 ref_clk = ~ref_clk;
	// Action pulses indexed by code
	assign pulses = {act_run_script, act_invert_dir, act_rev_limit, act_fwd_limit,
		act_motor_stop, act_emergency_stop, act_safety_stop, 1'b0};
	// Pulses stand one cycle only, so tally them at every edge
	always @(posedge ref_clk) begin
		for (int k = 1; k < 8; k++) if (pulses[k] === 1'b1) hits[k]++;
		if (zero_seek_active === 1'b1) seek_n++;
		rpm_sum += speed_rpm;
	end
	// ************************************************
	// Helpers
	// ************************************************
	// Travel target, truncated toward zero like the integer divide
	function automatic int tgt(longint l, longint h, longint k);
		return int'(l + (h - l) * (k + 1000) / 2000);
	endfunction : tgt
	task automatic close_out();
		if (errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wait_n(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_n
	task automatic wcfg(logic [3:0] it, logic [31:0] d, logic [2:0] ix = 3'h1);
		@(posedge ref_clk);
		{cfg_wr, cfg_item, cfg_data, cfg_index} <= {1'b1, it, d, ix};
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
	endtask : wcfg
	// 0 home command, 1 script home, 2 bind
	task automatic hit(int which);
		@(posedge ref_clk);
		{bind_zero_search_command, script_home, home_cmd} <= 3'h1 << which;
		@(posedge ref_clk);
		{bind_zero_search_command, script_home, home_cmd} <= 3'h0;
	endtask : hit
	// Spaced so each sector is decoded before the next arrives
	task automatic step(int n, bit up);
		repeat (n) begin
			@(posedge ref_clk);
			{fwd, rev} <= {up, !up};
			@(posedge ref_clk);
			{fwd, rev} <= 2'h0;
			repeat (5) @(posedge ref_clk);
		end
	endtask : step
	// ************************************************
	// Tests
	// ************************************************
	initial begin
		seed = $urandom(66);
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		wait_n(2);
		chk("mode", 0, commutation_mode_select);
		chk("poles", 2, pole_pair_count);
		chk("seek_cur", 50, zero_seek_current);
		chk("spacing", 0, hall_spacing_select);
		chk("map", 0, hall_winding_map);
		chk("gain", 0, foc_integral_gain);
		chk("referenced", 0, count_referenced);
		for (int i = 0; i < 10; i++) begin
			lo = i < 2 ? -20000 : int'($urandom_range(1000000)) - 1000000;
			hi = i < 2 ? 20000 : int'($urandom_range(1000000));
			c = i == 0 ? -1000 : i == 1 ? 1000 : int'($urandom_range(2000)) - 1000;
			if (i > 1) begin
				wcfg(CFG_UPPER_LIMIT, hi);
				wcfg(CFG_LOWER_LIMIT, lo);
			end
			@(posedge ref_clk) rel_cmd <= 12'(c);
			wait_n(3);
			chk("target", tgt(lo, hi, c), target_position);
		end
		wcfg(CFG_HALL_MAP, 3);
		wcfg(CFG_HALL_MAP, 6);
		wcfg(CFG_HALL_SPACING, 1);
		wcfg(CFG_POLE_PAIRS, -3);
		wcfg(CFG_POLE_PAIRS, 200);
		wcfg(CFG_FOC_GAIN, 8'hAB, 3'h2);
		wcfg(CFG_FOC_GAIN, 8'h55, 3'h0);
		wcfg(CFG_SEEK_CURRENT, 75);
		wait_n(2);
		chk("map", 3, hall_winding_map);
		chk("spacing", 1, hall_spacing_select);
		chk("poles", -3, pole_pair_count);
		chk("gain", 32'h0000AB00, foc_integral_gain);
		chk("seek_cur", 75, zero_seek_current);
		wcfg(CFG_HALL_MAP, 0);
		wcfg(CFG_HALL_SPACING, 0);
		// Remapping static pins can step the count; restart from home
		hit(0);
		wait_n(33);
		rpm_sum = 0;
		step(2, 1'b1);
		wait_n(4);
		chk("count", -2, hall_count);
		// One or two windows of 16 cycles; either way the sum is the same
		wait_n(33);
		chk("rpm", -2 * 16 * (RPM_SCALE / 3), rpm_sum);
		wcfg(CFG_POLE_PAIRS, 2);
		// Counter loads happen with the channel idle, as the host must ensure
		for (int j = 0; j < 3; j++) begin
			v = int'($urandom_range(30000)) - 15000;
			wcfg(CFG_HOME_VALUE, v);
			if (j < 2) hit(j);
			else begin
				@(posedge ref_clk) home_switch <= 1'b1;
				wait_n(6);
				@(posedge ref_clk) home_switch <= 1'b0;
			end
			wait_n(4);
			chk("count", v, hall_count);
			chk("referenced", 1, count_referenced);
			chk("turns", v / 12, motor_turns);
		end
		wcfg(CFG_HOME_VALUE, 0);
		hit(0);
		wcfg(CFG_UPPER_LIMIT, 1);
		wcfg(CFG_LOWER_LIMIT, -1);
		for (c = 1; c < 9; c++) begin
			m = int'($urandom_range(3));
			wcfg(c % 2 ? CFG_UPPER_ACTION : CFG_LOWER_ACTION, {2'h0, m[1:0], c[3:0]});
			wait_n(1);
			hits = '{default: 0};
			step(3, c % 2);
			wait_n(4);
			chk("count", c == 8 ? -1 : (c % 2 ? 3 : -3), hall_count);
			chk("pulses", c == 8 ? 0 : 1, hits.sum());
			chk("decode", c == 8 ? 0 : 1, hits[c]);
			chk("motor", m, act_motor);
			hit(0);
		end
		seek_n = 0;
		for (int k = 0; k < 4; k++) begin
			wcfg(CFG_MODE, k);
			wait_n(2);
			chk("mode", k, commutation_mode_select);
		end
		wait_n(12);
		chk("seek_len", SEEK, seek_n);
		@(posedge ref_clk) feedback_select <= FBK_SPI;
		wcfg(CFG_MODE, 1);
		wcfg(CFG_MODE, 5);
		wait_n(12);
		seek_n = 0;
		hit(2);
		wait_n(12);
		chk("bind_len", SEEK, seek_n);
		chk("mode", 1, commutation_mode_select);
		close_out();
	end
	// Hang guard, well beyond the few hundred cycles the tests take
	initial begin
		repeat (40000) @(posedge ref_clk);
		errors++;
		close_out();
	end
endmodule : hall_counter_soft_limits_tb
